// ---- logic/ltc_defs.svh ----
`ifndef LTC_DEFS_SVH
`define LTC_DEFS_SVH
// ==========================================
// Tile geometry
`define LTC_CELLS 8
`define LTC_NETS 8
// ==========================================
// Register byte addresses
`define LTC_ADR_CTRL 8'h00
`define LTC_ADR_MODE 8'h04
`define LTC_ADR_STAT 8'h08
`define LTC_ADR_LUT0 8'h20
// ==========================================
// Field positions
`define LTC_CTRL_RUN 0
`define LTC_MODE_REGO 0
`define LTC_MODE_CIN 8
`define LTC_MODE_SRA 16
`define LTC_MODE_SRS 17
`define LTC_MODE_SRG 19
`define LTC_MODE_CES 21
`define LTC_MODE_CEG 23
`define LTC_MODE_CKF 25
`define LTC_MODE_CKG 26
`define LTC_STAT_FF 0
`define LTC_STAT_OUT 8
`define LTC_STAT_CARRY 16
`define LTC_STAT_RUN 17
// ==========================================
// Reset values
`define LTC_MODE_RST 32'h0000_0000
`define LTC_LUT_RST 16'h0000
`endif

// ---- logic/ltc_pkg.sv ----
package ltc_pkg;
  // Source of the shared set/reset or clock enable
  typedef enum logic [1:0] {
    LTC_SRC_NONE = 2'h0,
    LTC_SRC_GLOBAL = 2'h1,
    LTC_SRC_FABRIC = 2'h2,
    LTC_SRC_RSVD = 2'h3
  } ltc_src_t;
endpackage

// ---- logic/ltc_logic_tile.sv ----
// What this block does
// - Eight cells, each one lookup and one flop
// - Four-input lookup acts as sixteen-bit table
// - Flop has optional enable and reset controls
// - Device-wide reset clears flops after configuration
// - Carry chain from fast carry in to out
// - One clock enable gates all eight flops
// - Shared set/reset, asynchronous or synchronous mode
// - Clock from eight global nets or fabric
// - Cell output is lookup or flop value
// - Unused set/reset never clears, except after configuration
// - Wake-up state of every flop is reset
// - Even nets drive reset, odd nets enable
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "ltc_defs.svh"
module ltc_logic_tile import ltc_pkg::*; (
  // System
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Clock and control pins from outside
  input wire logic [7:0] GLOBAL_NET,
  input wire logic FABRIC_CLK,
  // Fabric signals on the system clock
  input wire logic FABRIC_CE,
  input wire logic FABRIC_SR,
  input wire logic [31:0] CELL_IN,
  input wire logic FAST_CARRY_INPUT,
  // Cell results
  output logic [7:0] CELL_OUT,
  output logic FAST_CARRY_OUTPUT
);

  // ==========================================
  // Helpers
  function automatic logic maj(input logic a, input logic b, input logic c);
    maj = (a & b) | (a & c) | (b & c);
  endfunction

  // ==========================================
  // Pin synchronisers
  // Bits 7:0 follow the global nets, bit 8 the fabric clock
  logic [8:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [8:0] s1_next, s2_next, s3_next, lvl_next, rise;

  // Level moves only once stages two and three agree
  always_comb begin
    s1_next = {FABRIC_CLK, GLOBAL_NET};
    s2_next = s1_reg;
    s3_next = s2_reg;
    lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
    rise = lvl_next & ~lvl_reg;
  end

  // Stages reset low, matching the idle low level of the nets
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      s1_reg <= 9'h000;
      s2_reg <= 9'h000;
      s3_reg <= 9'h000;
      lvl_reg <= 9'h000;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      lvl_reg <= lvl_next;
    end
  end

  // ==========================================
  // Register file and bus slave
  logic run_reg, run_next, ack_reg, ack_next, wr;
  logic [31:0] mode_reg, mode_next, dat_reg, dat_next, stat;
  logic [15:0] lut_reg [`LTC_CELLS];
  logic [15:0] lut_next [`LTC_CELLS];
  logic [7:0] ff_reg, ff_next;
  logic lut_hit;

  // Lookup window on word boundaries above the fixed registers
  assign lut_hit = (WB_ADR_I[7:5] == 3'(`LTC_ADR_LUT0 >> 5)) && (WB_ADR_I[1:0] == 2'h0);
  // A write lands only at the edge that sees ack high, where the master takes it
  assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ack_reg;

  // Configuration is locked while running so the tile never sees it change
  always_comb begin
    run_next = run_reg;
    mode_next = mode_reg;
    lut_next = lut_reg;
    ack_next = WB_CYC_I & WB_STB_I & ~ack_reg;
    dat_next = 32'h0000_0000;
    if (wr && WB_ADR_I == `LTC_ADR_CTRL && WB_SEL_I[0]) begin
      run_next = WB_DAT_I[`LTC_CTRL_RUN];
    end
    if (wr && !run_reg && WB_ADR_I == `LTC_ADR_MODE) begin
      for (int b = 0; b < 4; b++) begin
        if (WB_SEL_I[b]) begin
          mode_next[8*b+:8] = WB_DAT_I[8*b+:8];
        end
      end
    end
    if (wr && !run_reg && lut_hit) begin
      for (int b = 0; b < 2; b++) begin
        if (WB_SEL_I[b]) begin
          lut_next[WB_ADR_I[4:2]][8*b+:8] = WB_DAT_I[8*b+:8];
        end
      end
    end
    if (ack_next) begin
      if (WB_ADR_I == `LTC_ADR_CTRL) begin
        dat_next[`LTC_CTRL_RUN] = run_reg;
      end else if (WB_ADR_I == `LTC_ADR_MODE) begin
        dat_next = mode_reg;
      end else if (WB_ADR_I == `LTC_ADR_STAT) begin
        dat_next = stat;
      end else if (lut_hit) begin
        dat_next[15:0] = lut_reg[WB_ADR_I[4:2]];
      end
    end
  end

  // Reset leaves the tile stopped, tables empty and every cell in lookup mode
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      run_reg <= 1'b0;
      mode_reg <= `LTC_MODE_RST;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      for (int i = 0; i < `LTC_CELLS; i++) begin
        lut_reg[i] <= `LTC_LUT_RST;
      end
    end else begin
      run_reg <= run_next;
      mode_reg <= mode_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      lut_reg <= lut_next;
    end
  end

  // Ack and read data come straight from flops, one cycle after the request
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;

  // ==========================================
  // Shared tile controls
  ltc_src_t sr_src, ce_src;
  logic [1:0] sr_gsel, ce_gsel;
  logic [2:0] ck_gsel;
  logic sr_async, ck_fab, tick, sr_on, ce_ok, gr, sr_now;

  // Mode fields decoded once; they stay static while the tile runs
  assign sr_src = ltc_src_t'(mode_reg[`LTC_MODE_SRS+:2]);
  assign ce_src = ltc_src_t'(mode_reg[`LTC_MODE_CES+:2]);
  assign sr_gsel = mode_reg[`LTC_MODE_SRG+:2];
  assign ce_gsel = mode_reg[`LTC_MODE_CEG+:2];
  assign ck_gsel = mode_reg[`LTC_MODE_CKG+:3];
  assign sr_async = mode_reg[`LTC_MODE_SRA];
  assign ck_fab = mode_reg[`LTC_MODE_CKF];
  // Tile clock is an enable pulse on a rising edge of the chosen source
  assign tick = ck_fab ? rise[8] : rise[ck_gsel];
  // Set/reset and enable both sit at the global reset of configuration end
  assign gr = run_next & ~run_reg;

  // Set/reset only reads even nets, enable only reads odd nets
  always_comb begin
    case (sr_src)
      LTC_SRC_GLOBAL: sr_on = lvl_reg[{sr_gsel, 1'b0}];
      LTC_SRC_FABRIC: sr_on = FABRIC_SR;
      default: sr_on = 1'b0;
    endcase
    case (ce_src)
      LTC_SRC_GLOBAL: ce_ok = lvl_reg[{ce_gsel, 1'b1}];
      LTC_SRC_FABRIC: ce_ok = FABRIC_CE;
      default: ce_ok = 1'b1;
    endcase
  end

  // Asynchronous mode clears on every system clock while the source is active
  assign sr_now = sr_async & sr_on;

  // ==========================================
  // Cells: lookup, carry and flop
  // carry[i] runs into cell i, carry[8] leaves the tile
  logic [3:0] idx [`LTC_CELLS];
  logic [8:0] carry;
  logic [7:0] lut_val, d_vec;

  // Carry may replace the top lookup input, which is how a sum bit is built
  always_comb begin
    carry[0] = FAST_CARRY_INPUT;
    for (int i = 0; i < `LTC_CELLS; i++) begin
      idx[i] = CELL_IN[4*i+:4];
      if (mode_reg[`LTC_MODE_CIN+i]) begin
        idx[i][3] = carry[i];
      end
      lut_val[i] = lut_reg[i][idx[i]];
      carry[i+1] = maj(idx[i][1], idx[i][2], carry[i]);
    end
    d_vec = lut_val;
  end

  // Global clear first, then asynchronous clear, then the tile clock
  always_comb begin
    ff_next = ff_reg;
    if (gr) begin
      ff_next = 8'h00;
    end else if (sr_now) begin
      ff_next = 8'h00;
    end else if (tick) begin
      if (sr_on) begin
        ff_next = 8'h00;
      end else if (ce_ok) begin
        ff_next = d_vec;
      end
    end
  end

  // The flops only register; every decision sits in the block above
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ff_reg <= 8'h00;
    end else begin
      ff_reg <= ff_next;
    end
  end

  // Asynchronous clear shows at once, before the flop itself updates
  always_comb begin
    for (int i = 0; i < `LTC_CELLS; i++) begin
      CELL_OUT[i] = mode_reg[`LTC_MODE_REGO+i] ? (ff_reg[i] & ~sr_now) : lut_val[i];
    end
  end

  assign FAST_CARRY_OUTPUT = carry[8];
  // Status mirrors flops, outputs, carry out and run state for software
  assign stat = {14'h0000, run_reg, carry[8], CELL_OUT, ff_reg};

  // ==========================================
  // Checks: configuration and wake-up
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  a_wake_reset: assert property ($rose(run_reg) |-> ff_reg == 8'h00)
    else $error("flops not cleared at configuration end");
  a_cfg_static: assert property (run_reg && $past(run_reg) |-> $stable(mode_reg))
    else $error("mode changed while running");
  a_gr_clear: assert property (gr |=> ff_reg == 8'h00)
    else $error("flops not cleared by global reset");

  // ==========================================
  // Checks: shared enable and set/reset
  a_ce_gate: assert property (tick && !ce_ok && !sr_on && !gr |=> $stable(ff_reg))
    else $error("flop loaded while enable low");
  a_ce_load: assert property (tick && ce_ok && !sr_on && !gr
    |=> ff_reg == $past(d_vec))
    else $error("flop not loaded on enabled tick");
  a_sr_async: assert property (sr_now && !gr |-> ##1 ff_reg == 8'h00)
    else $error("asynchronous clear missed");
  a_sr_sync: assert property (!sr_async && sr_on && tick && !gr |=> ff_reg == 8'h00)
    else $error("synchronous clear missed");
  // Forcing registered outputs low hides a stale flop value from the fabric
  a_async_out: assert property (sr_now
    |-> (CELL_OUT & mode_reg[`LTC_MODE_REGO+:8]) == 8'h00)
    else $error("output not forced low by clear");
  a_sr_unused: assert property (sr_src == LTC_SRC_NONE && tick && ce_ok && !gr
    |=> ff_reg == $past(d_vec))
    else $error("flop not loaded with reset unused");
  a_sr_none: assert property (sr_src == LTC_SRC_NONE || sr_src == LTC_SRC_RSVD
    |-> !sr_on)
    else $error("unused set/reset still active");
  a_ff_hold: assert property (!tick && !gr && !sr_now |=> $stable(ff_reg))
    else $error("flop changed without tile clock");
  a_gr_even: assert property (sr_src == LTC_SRC_GLOBAL && sr_gsel == 2'h1
    |-> sr_on == lvl_reg[2])
    else $error("reset taken from wrong net");
  a_ce_odd: assert property (ce_src == LTC_SRC_GLOBAL && ce_gsel == 2'h0
    |-> ce_ok == lvl_reg[1])
    else $error("enable taken from wrong net");
  // One source edge must give one tile clock, never a burst
  a_tick_once: assert property (tick && run_reg |=> !tick)
    else $error("tile clock pulse too long");

  // ==========================================
  // Checks: lookup, output select and carry
  a_lut_comb: assert property (!mode_reg[0] && !mode_reg[`LTC_MODE_CIN]
    |-> CELL_OUT[0] == lut_reg[0][CELL_IN[3:0]])
    else $error("lookup output wrong");
  a_reg_out: assert property (mode_reg[7] && !sr_now |-> CELL_OUT[7] == ff_reg[7])
    else $error("registered output wrong");
  a_carry_gen: assert property ((&{CELL_IN[30:29], CELL_IN[2:1]}) |-> carry[1] && carry[8])
    else $error("carry not generated");
  a_carry_in: assert property (!mode_reg[`LTC_MODE_REGO] && mode_reg[`LTC_MODE_CIN]
    |-> CELL_OUT[0] == lut_reg[0][{FAST_CARRY_INPUT, CELL_IN[2:0]}])
    else $error("carry not fed into lookup");
  a_carry_kill: assert property (!CELL_IN[30] && !CELL_IN[29] |-> !FAST_CARRY_OUTPUT)
    else $error("carry out without generate or propagate");

endmodule

// ---- test/ltc_fabric_model.sv ----
`timescale 1ns/1ns
// ==========================================
// Routing fabric clock source beside the tile
module ltc_fabric_model (
  // Clock and request
  input wire logic clk,
  input wire logic tick_req,
  // Routed clock toward the tile
  output logic fabric_clk
);
  int cnt = 0;
  initial fabric_clk = 1'b0;
  // Each level held five cycles so the tile's pin synchroniser sees a clean edge
  always @(posedge clk) begin
    if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 5) fabric_clk <= 1'b0;
    end else if (tick_req) begin
      cnt <= 9;
      fabric_clk <= 1'b1;
    end
  end
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ns
`include "ltc_defs.svh"
// ==========================================
// Tile bench with a behavioural lookup and flop model
module testbench;
  logic sys_clk, rstn, cyc, stb, we, ack, fci, fco, fce, fsr, tick_req, fclk;
  logic [7:0] adr, cout, gnet, ff, rmask;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, cin, rd, mode;
  int err_count = 0, checks_done = 0, seed = 49139, cycles = 0;
  int lut [8];
  // Lower byte: registered cells; clock, enable and set/reset sources above it
  logic [31:0] cfg [4] = '{32'h0244_00FF, 32'h0C23_000F, 32'h0200_00F0, 32'h0C0A_A53C};
  // Nets 0 and 2 carry set/reset, net 1 the enable, net 3 the clock
  assign gnet = {4'h0, fclk, fsr, fce, fsr};
  ltc_logic_tile dut (.SYS_CLK(sys_clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .GLOBAL_NET(gnet), .FABRIC_CLK(fclk), .FABRIC_CE(fce),
    .FABRIC_SR(fsr), .CELL_IN(cin), .FAST_CARRY_INPUT(fci), .CELL_OUT(cout),
    .FAST_CARRY_OUTPUT(fco));
  ltc_fabric_model fabric (.clk(sys_clk), .tick_req(tick_req), .fabric_clk(fclk));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One classic cycle, then one idle cycle so the next request never collides
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge sys_clk);
    while (ack !== 1'b1 && n < 50) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 50) chk("ack", 1, 0);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Lookup model; a set carry bit feeds the running carry into input 3
  function automatic logic [7:0] lut_out();
    logic [7:0] o;
    logic [3:0] x;
    logic c;
    c = fci;
    for (int i = 0; i < 8; i++) begin
      x = cin[4*i+:4];
      if (mode[8+i]) x[3] = c;
      o[i] = lut[i][x];
      c = (x[1] & x[2]) | (c & (x[1] | x[2]));
    end
    return o;
  endfunction
  function automatic logic carry_out();
    logic c;
    c = fci;
    for (int i = 0; i < 8; i++) c = (cin[4*i+1] & cin[4*i+2]) | (c & (cin[4*i+1] | cin[4*i+2]));
    return c;
  endfunction
  // Model: set/reset wins over enable; an unused source never acts
  task automatic step(input logic ce, input logic sr);
    fce <= ce;
    fsr <= sr;
    cin <= $random(seed);
    repeat (4) @(posedge sys_clk);
    tick_req <= 1'b1;
    @(posedge sys_clk);
    tick_req <= 1'b0;
    repeat (14) @(posedge sys_clk);
    if (sr && mode[18:17] inside {2'h1, 2'h2}) ff = 8'h00;
    else if (ce || !(mode[22:21] inside {2'h1, 2'h2})) ff = lut_out();
    wb(0, `LTC_ADR_STAT, 0);
    chk("flops", {24'h0, ff}, {24'h0, rd[7:0]});
    chk("carry", {31'h0, carry_out()}, {31'h0, fco});
    chk("cell_out", {24'h0, (ff & rmask) | (lut_out() & ~rmask)}, {24'h0, cout});
  endtask
  initial begin
    {rstn, cyc, stb, we, adr, wdat, cin, fci, fce, fsr, tick_req, mode} = '0;
    sel = 4'hF;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    wb(0, `LTC_ADR_MODE, 0);
    chk("mode", `LTC_MODE_RST, rd);
    wb(0, `LTC_ADR_STAT, 0);
    chk("stat", 0, rd);
    wb(0, 8'hF0, 0);
    chk("unmapped", 0, rd);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      lut[i] = $random(seed) & 32'h0000_FFFF;
      wb(1, 8'(`LTC_ADR_LUT0 + 4 * i), lut[i]);
    end
    wb(0, `LTC_ADR_LUT0 + 8'h1C, 0);
    chk("lut7", lut[7], rd);
    repeat (20) begin
      cin <= $random(seed);
      fci <= 1'($random(seed));
      @(posedge sys_clk);
      chk("lookup", {24'h0, lut_out()}, {24'h0, cout});
      chk("carry", {31'h0, carry_out()}, {31'h0, fco});
    end
    $display("test lookup done");
    foreach (cfg[k]) begin
      mode = cfg[k];
      rmask = mode[7:0];
      wb(1, `LTC_ADR_CTRL, 0);
      wb(1, `LTC_ADR_MODE, mode);
      wb(1, `LTC_ADR_CTRL, 1);
      ff = 8'h00;
      wb(0, `LTC_ADR_STAT, 0);
      chk("wake", 32'h0002_0000, rd & 32'h0002_00FF);
      step(1, 0);
      step(0, 0);
      step(0, 1);
      step(1, 1);
      step(1, 0);
      wb(1, `LTC_ADR_MODE, 0);
      wb(0, `LTC_ADR_MODE, 0);
      chk("mode_locked", mode, rd);
    end
    $display("test flops done");
    finish_test();
  end
endmodule
